// [include/rqs_pkg.sv]
// Purpose: Shared constants for the read-direction error and queue scheduler block.
// Assumes: APB slave with 32-bit data, one clock, synchronous active-high reset.
// Notes:   Offsets are byte addresses.
package rqs_pkg;

    localparam logic [7:0]  ERR_STATUS_OFFSET   = 8'h10;
    localparam logic [7:0]  SCHED_TYPE_OFFSET   = 8'h14;
    localparam logic [7:0]  WEIGHT_LOW_OFFSET   = 8'h18;
    localparam logic [7:0]  WEIGHT_HIGH_OFFSET  = 8'h1C;
    localparam logic [7:0]  CONTROL_OFFSET      = 8'h30;
    localparam logic [7:0]  STATUS_OFFSET       = 8'h34;
    localparam logic [7:0]  IRQ_STATUS_OFFSET   = 8'h38;
    localparam logic [7:0]  IRQ_MASK_OFFSET     = 8'h3C;

    localparam int          ERR_INTERNAL_BIT    = 0;
    localparam int          ERR_SLAVE_BIT       = 1;
    localparam int          SCHED_STRICT_BIT    = 0;
    localparam int          SCHED_WRR_BIT       = 1;
    localparam int          SCHED_FAIR_BIT      = 2;
    localparam int          CTRL_RUN_BIT        = 0;
    localparam int          STAT_HALTED_BIT     = 0;
    localparam int          STAT_IDLE_BIT       = 1;
    localparam int          IRQ_HALT_BIT        = 0;
    localparam int          IRQ_ERROR_BIT       = 1;

    localparam logic [2:0]  SCHED_STRICT        = 3'h1;
    localparam logic [2:0]  SCHED_WRR           = 3'h2;
    localparam logic [2:0]  SCHED_FAIR          = 3'h4;
    localparam logic [3:0]  WEIGHT_RESET        = 4'h1;
    localparam int          WEIGHT_W            = 4;

    // Configured scheduler: 0 programmable, 1 strict priority, 2 fair round robin.
    localparam logic [1:0]  CFG_PROGRAMMABLE    = 2'h0;
    localparam logic [1:0]  CFG_STRICT          = 2'h1;
    localparam logic [1:0]  CFG_FAIR            = 2'h2;

    typedef enum logic [1:0]
    {
        RQS_MODE_STRICT = 2'b00,
        RQS_MODE_WRR    = 2'b01,
        RQS_MODE_FAIR   = 2'b10
    } rqs_mode_t;

    typedef enum logic [1:0]
    {
        RQS_IDLE     = 2'b00,
        RQS_RUN      = 2'b01,
        RQS_DRAIN    = 2'b10,
        RQS_HALTED   = 2'b11
    } rqs_state_t;

endpackage

// [rtl/rqs_weight_bank.sv]
// Purpose: Per-channel weight storage with iteration-boundary snapshot.
// Assumes: Lowest channel of each word sits in bits 3:0.
// Notes:   Stored values change at once; active values only on iter_start.
`timescale 1ns/1ps
module rqs_weight_bank #(
    parameter int NUM_CH = 16
) (
    // Clock and reset
    input  wire logic                           ref_clk,
    input  wire logic                           reset,
    // Write port
    input  wire logic                           wr_low,
    input  wire logic                           wr_high,
    input  wire logic [31:0]                    wr_data,
    input  wire logic [3:0]                     wr_strb,
    // Iteration boundary
    input  wire logic                           iter_start,
    // Views
    output logic      [NUM_CH*4-1:0]            stored_weights,
    output logic      [NUM_CH*4-1:0]            active_weights
);

    logic [NUM_CH*4-1:0] stored_q;
    logic [NUM_CH*4-1:0] stored_d;
    logic [NUM_CH*4-1:0] active_q;
    logic [NUM_CH*4-1:0] active_d;

    // Two 32-bit words hold at most sixteen four-bit fields.
    if (NUM_CH < 1 || NUM_CH > 16)
    begin
        $error("rqs_weight_bank: NUM_CH must be 1 to 16");
    end

    always_comb
    begin
        stored_d = stored_q;
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (i < 8 && wr_low && wr_strb[i/2])
                stored_d[i*4 +: 4] = wr_data[(i%8)*4 +: 4];
            if (i >= 8 && wr_high && wr_strb[(i-8)/2])
                stored_d[i*4 +: 4] = wr_data[(i%8)*4 +: 4];
        end
        active_d = iter_start ? stored_q : active_q;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            stored_q <= {NUM_CH{rqs_pkg::WEIGHT_RESET}};
            active_q <= {NUM_CH{rqs_pkg::WEIGHT_RESET}};
        end
        else
        begin
            stored_q <= stored_d;
            active_q <= active_d;
        end
    end

    assign stored_weights = stored_q;
    assign active_weights = active_q;

endmodule

// [rtl/rqs_top.sv]
// Purpose: Read-direction error status and queue scheduler control registers.
// Assumes: APB slave; engine events arrive as one-cycle pulses from the datapath.
// Notes:   Errors clear only through reset; the engine is told to stop and reports when drained.
// What this block does
// - Read slave error sets bit 1, halts
// - Error clears run bit; halted after shutdown
// - Zero-length descriptor sets bit 0, halts
// - Error bits read-only, reset zero, shared
// - Scheduler bits: fair, weighted, strict priority
// - Scheduler writable only when configured programmable
// - Invalid scheduler codes act as weighted
// - Scheduler reset value follows configuration
// - Four-bit weights, channels 1-8 then 9-16
// - Weight is packets per iteration, resets one
// - Disabled-channel weight write only stores value
// - New weights apply at iteration start
// - Any error halts all; reset clears
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module rqs_top #(
    parameter int         NUM_CH        = 16,
    parameter logic [1:0] SCHED_CONFIG  = rqs_pkg::CFG_PROGRAMMABLE
) (
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   reset,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // Engine events
    input  wire logic                   data_read_slave_error,
    input  wire logic                   zero_length_descriptor,
    input  wire logic                   engine_idle,
    input  wire logic                   iter_start,
    input  wire logic [NUM_CH-1:0]      channel_enable,
    // Engine control
    output logic                        run_stop_bit,
    output logic                        halted_flag,
    output rqs_pkg::rqs_mode_t          sched_mode,
    output logic      [NUM_CH*4-1:0]    active_weights,
    output logic                        irq
);

    // Only the three configured schemes have a defined reset code.
    if (SCHED_CONFIG > rqs_pkg::CFG_FAIR)
    begin
        $error("rqs_top: SCHED_CONFIG must be 0, 1 or 2");
    end

    localparam logic [2:0] SCHED_RESET =
        (SCHED_CONFIG == rqs_pkg::CFG_STRICT) ? rqs_pkg::SCHED_STRICT :
        (SCHED_CONFIG == rqs_pkg::CFG_FAIR)   ? rqs_pkg::SCHED_FAIR   : rqs_pkg::SCHED_WRR;

    function automatic logic [31:0] bytes_merge(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
                r[b*8 +: 8] = new_v[b*8 +: 8];
        end
        return r;
    endfunction

    rqs_pkg::rqs_state_t state_q;
    rqs_pkg::rqs_state_t state_d;
    logic [1:0]          err_q;
    logic [1:0]          err_d;
    logic [2:0]          sched_q;
    logic [2:0]          sched_d;
    logic                run_q;
    logic                run_d;
    logic [1:0]          irq_stat_q;
    logic [1:0]          irq_stat_d;
    logic [1:0]          irq_mask_q;
    logic [1:0]          irq_mask_d;
    logic [31:0]         rdata_q;
    logic [31:0]         rdata_d;
    logic                slverr_q;
    logic                slverr_d;
    logic                wr_en;
    logic                rd_en;
    logic                mapped;
    logic                any_error;
    logic                halt_done;
    logic [NUM_CH*4-1:0] stored_weights;
    logic [31:0]         wlow_view;
    logic [31:0]         whigh_view;
    logic [31:0]         wr_merged;

    assign wr_en  = psel && penable && pwrite;
    assign rd_en  = psel && penable && !pwrite;
    assign pready = psel && penable;

    always_comb
    begin
        unique case (paddr)
            rqs_pkg::ERR_STATUS_OFFSET,
            rqs_pkg::SCHED_TYPE_OFFSET,
            rqs_pkg::WEIGHT_LOW_OFFSET,
            rqs_pkg::WEIGHT_HIGH_OFFSET,
            rqs_pkg::CONTROL_OFFSET,
            rqs_pkg::STATUS_OFFSET,
            rqs_pkg::IRQ_STATUS_OFFSET,
            rqs_pkg::IRQ_MASK_OFFSET: mapped = 1'b1;
            default:                  mapped = 1'b0;
        endcase
    end

    // Weights are stored only; masking by enable happens downstream of storage.
    rqs_weight_bank #(
        .NUM_CH         (NUM_CH)
    ) u_weights (
        .ref_clk        (ref_clk),
        .reset          (reset),
        .wr_low         (wr_en && paddr == rqs_pkg::WEIGHT_LOW_OFFSET),
        .wr_high        (wr_en && paddr == rqs_pkg::WEIGHT_HIGH_OFFSET),
        .wr_data        (pwdata),
        .wr_strb        (pstrb),
        .iter_start     (iter_start),
        .stored_weights (stored_weights),
        .active_weights (active_weights)
    );

    always_comb
    begin
        wlow_view  = 32'h0000_0000;
        whigh_view = 32'h0000_0000;
        for (int i = 0; i < NUM_CH; i++)
        begin
            if (i < 8)
                wlow_view[i*4 +: 4] = stored_weights[i*4 +: 4];
            else
                whigh_view[(i-8)*4 +: 4] = stored_weights[i*4 +: 4];
        end
    end

    assign any_error = data_read_slave_error || zero_length_descriptor;
    assign halt_done = (state_q == rqs_pkg::RQS_DRAIN) && engine_idle;
    assign wr_merged = bytes_merge(32'h0000_0000, pwdata, pstrb);

    always_comb
    begin
        state_d    = state_q;
        err_d      = err_q;
        sched_d    = sched_q;
        run_d      = run_q;
        irq_stat_d = irq_stat_q;
        irq_mask_d = irq_mask_q;
        rdata_d    = rdata_q;
        slverr_d   = 1'b0;

        if (wr_en)
        begin
            unique case (paddr)
                rqs_pkg::SCHED_TYPE_OFFSET:
                begin
                    if (SCHED_CONFIG == rqs_pkg::CFG_PROGRAMMABLE && pstrb[0])
                        sched_d = pwdata[2:0];
                end
                rqs_pkg::CONTROL_OFFSET:
                begin
                    // Restart is refused while errors are recorded; only reset clears them.
                    if (pstrb[0] && err_q == 2'h0)
                        run_d = pwdata[rqs_pkg::CTRL_RUN_BIT];
                end
                rqs_pkg::IRQ_STATUS_OFFSET:
                    irq_stat_d = irq_stat_q & ~wr_merged[1:0];
                rqs_pkg::IRQ_MASK_OFFSET:
                begin
                    if (pstrb[0])
                        irq_mask_d = pwdata[1:0];
                end
                default:
                    slverr_d = !mapped;
            endcase
        end

        if (rd_en)
        begin
            slverr_d = !mapped;
            unique case (paddr)
                rqs_pkg::ERR_STATUS_OFFSET:  rdata_d = {30'h0, err_q};
                rqs_pkg::SCHED_TYPE_OFFSET:  rdata_d = {29'h0, sched_q};
                rqs_pkg::WEIGHT_LOW_OFFSET:  rdata_d = wlow_view;
                rqs_pkg::WEIGHT_HIGH_OFFSET: rdata_d = whigh_view;
                rqs_pkg::CONTROL_OFFSET:     rdata_d = {31'h0, run_q};
                rqs_pkg::STATUS_OFFSET:      rdata_d = {30'h0, engine_idle, state_q == rqs_pkg::RQS_HALTED};
                rqs_pkg::IRQ_STATUS_OFFSET:  rdata_d = {30'h0, irq_stat_q};
                rqs_pkg::IRQ_MASK_OFFSET:    rdata_d = {30'h0, irq_mask_q};
                default:                     rdata_d = 32'h0000_0000;
            endcase
        end

        if (data_read_slave_error)
            err_d[rqs_pkg::ERR_SLAVE_BIT] = 1'b1;
        if (zero_length_descriptor)
            err_d[rqs_pkg::ERR_INTERNAL_BIT] = 1'b1;

        unique case (state_q)
            rqs_pkg::RQS_IDLE:
            begin
                if (run_d)
                    state_d = rqs_pkg::RQS_RUN;
            end
            rqs_pkg::RQS_RUN:
            begin
                if (!run_d)
                    state_d = rqs_pkg::RQS_DRAIN;
            end
            rqs_pkg::RQS_DRAIN:
            begin
                if (engine_idle)
                    state_d = rqs_pkg::RQS_HALTED;
            end
            rqs_pkg::RQS_HALTED:
            begin
                if (run_d)
                    state_d = rqs_pkg::RQS_RUN;
            end
        endcase

        if (any_error)
        begin
            run_d      = 1'b0;
            irq_stat_d[rqs_pkg::IRQ_ERROR_BIT] = 1'b1;
            if (state_q != rqs_pkg::RQS_HALTED)
                state_d = rqs_pkg::RQS_DRAIN;
        end
        // Set wins over a same-cycle write-one clear.
        if (halt_done)
            irq_stat_d[rqs_pkg::IRQ_HALT_BIT] = 1'b1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state_q    <= rqs_pkg::RQS_IDLE;
            err_q      <= 2'h0;
            sched_q    <= SCHED_RESET;
            run_q      <= 1'b0;
            irq_stat_q <= 2'h0;
            irq_mask_q <= 2'h0;
            rdata_q    <= 32'h0000_0000;
            slverr_q   <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            err_q      <= err_d;
            sched_q    <= sched_d;
            run_q      <= run_d;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            rdata_q    <= rdata_d;
            slverr_q   <= slverr_d;
        end
    end

    always_comb
    begin
        unique case (sched_q)
            rqs_pkg::SCHED_STRICT: sched_mode = rqs_pkg::RQS_MODE_STRICT;
            rqs_pkg::SCHED_FAIR:   sched_mode = rqs_pkg::RQS_MODE_FAIR;
            default:               sched_mode = rqs_pkg::RQS_MODE_WRR;
        endcase
    end

    // Read data is decoded combinationally in the access phase and held in a register afterwards.
    always_comb
    begin
        prdata  = rd_en ? rdata_d : rdata_q;
        pslverr = pready && !mapped;
    end

    assign halted_flag  = state_q == rqs_pkg::RQS_HALTED;
    assign run_stop_bit = run_q;
    assign irq          = |(irq_stat_q & irq_mask_q);

    logic unused_ok;
    assign unused_ok = slverr_q ^ (|channel_enable);

endmodule

// [dv/rqs_engine_model.sv]
// Purpose: Behavioural datapath beside the read scheduler block.
// Assumes: Events are one-cycle pulses; the datapath drains in DRAIN cycles.
// Notes:   The drain delay proves that halting waits for the datapath.
`timescale 1ns/1ps
module rqs_engine_model #(
    parameter int DRAIN = 5
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic reset,
    // Control from the block
    input  wire logic run_stop_bit,
    // Engine events
    output logic      data_read_slave_error,
    output logic      zero_length_descriptor,
    output logic      engine_idle,
    output logic      iter_start
);
    int cnt = 0;
    initial
    begin
        data_read_slave_error = 1'h0;
        zero_length_descriptor = 1'h0;
        engine_idle = 1'h1;
        iter_start = 1'h0;
    end
    // Queues end on end-of-frame.
    // The drain counter runs down from DRAIN to zero once the run bit drops, so the drain finishes unless the run bit is set again.
    // Drain before idle.
    always @(posedge ref_clk)
    begin
        if (reset || run_stop_bit)
            cnt <= DRAIN;
        else if (cnt > 0)
            cnt <= cnt - 1;
        engine_idle <= !run_stop_bit && cnt == 0;
    end
    task automatic pulse_err(input logic slave);
        @(posedge ref_clk);
        data_read_slave_error <= slave;
        zero_length_descriptor <= !slave;
        @(posedge ref_clk);
        data_read_slave_error <= 1'h0;
        zero_length_descriptor <= 1'h0;
        @(posedge ref_clk);
    endtask
    task automatic iteration();
        @(posedge ref_clk);
        iter_start <= 1'h1;
        @(posedge ref_clk);
        iter_start <= 1'h0;
        @(posedge ref_clk);
    endtask
endmodule

// [dv/rqs_top_properties.sv]
// Purpose: Port-level properties of the read scheduler register block.
// Assumes: Zero-wait APB answers; one clock domain.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/1ps
module rqs_top_properties #(
    parameter int NUM_CH = 16
) (
    // Clock and reset
    input wire logic                  ref_clk,
    input wire logic                  reset,
    // APB
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [7:0]            paddr,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // Engine
    input wire logic                  data_read_slave_error,
    input wire logic                  zero_length_descriptor,
    input wire logic                  engine_idle,
    input wire logic                  iter_start,
    input wire logic                  run_stop_bit,
    input wire logic                  halted_flag,
    input wire rqs_pkg::rqs_mode_t    sched_mode,
    input wire logic [NUM_CH*4-1:0]   active_weights
);
    // A restart after a clean stop is legal; only a recorded error pins the halt until reset.
    logic err_seen_q;
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            err_seen_q <= 1'b0;
        else if (data_read_slave_error || zero_length_descriptor)
            err_seen_q <= 1'b1;
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    a_slave_stops: assert property (data_read_slave_error |=> !run_stop_bit)
        else $error("run bit stayed set after slave error");
    a_zero_stops: assert property (zero_length_descriptor |=> !run_stop_bit)
        else $error("run bit stayed set after zero length");
    a_halt_drained: assert property ($rose(halted_flag) |-> $past(engine_idle) && !run_stop_bit)
        else $error("halted before the engine drained");
    a_halt_holds: assert property (halted_flag && err_seen_q |=> halted_flag)
        else $error("halted flag cleared without reset");
    a_weights_hold: assert property (!iter_start |=> $stable(active_weights))
        else $error("active weights changed outside iteration start");
    a_err_rsvd: assert property (psel && penable && !pwrite && paddr == 8'h10 |-> prdata[31:2] == 30'h0)
        else $error("error register reserved bits not zero");
    a_sched_rsvd: assert property (psel && penable && !pwrite && paddr == 8'h14 |-> prdata[31:3] == 29'h0)
        else $error("scheduler register reserved bits not zero");
    a_mode_legal: assert property (sched_mode != 2'h3)
        else $error("scheduler mode outside the three schemes");
    a_unmapped_err: assert property (psel && penable && paddr == 8'h20 |-> pslverr && pready)
        else $error("unmapped access not refused");
endmodule

bind rqs_top rqs_top_properties #(.NUM_CH(NUM_CH)) u_props (.ref_clk, .reset, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .data_read_slave_error, .zero_length_descriptor, .engine_idle,
    .iter_start, .run_stop_bit, .halted_flag, .sched_mode, .active_weights);

// [dv/rqs_top_bench.sv]
// Purpose: Self-checking bench for the read scheduler register block.
// Assumes: Zero-wait APB slave; reads checked from a queue of expectations.
// Notes:   Second reset in mid-run shows that errors clear only by reset.
`timescale 1ns/1ps
module rqs_top_bench;
    logic               ref_clk;
    logic               reset;
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [7:0]         paddr;
    logic [31:0]        pwdata;
    logic [3:0]         pstrb;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic               data_read_slave_error;
    logic               zero_length_descriptor;
    logic               engine_idle;
    logic               iter_start;
    logic [15:0]        channel_enable;
    logic               run_stop_bit;
    logic               halted_flag;
    rqs_pkg::rqs_mode_t sched_mode;
    rqs_pkg::rqs_mode_t fixed_mode;
    logic [63:0]        active_weights;
    logic               irq;
    logic [32:0]        exp_q[$];
    logic [31:0]        wl;
    logic [31:0]        wh;
    int                 n_fail = 0;
    int                 checked = 0;

    rqs_top u_dut (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .data_read_slave_error, .zero_length_descriptor, .engine_idle, .iter_start,
        .channel_enable, .run_stop_bit, .halted_flag, .sched_mode, .active_weights, .irq);
    // Second instance configured for strict priority; it shares the bus so every scheduler write reaches it.
    rqs_top #(.SCHED_CONFIG(rqs_pkg::CFG_STRICT)) u_dut_fixed (.ref_clk, .reset, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata(), .pready(), .pslverr(), .data_read_slave_error,
        .zero_length_descriptor, .engine_idle, .iter_start, .channel_enable, .run_stop_bit(), .halted_flag(),
        .sched_mode(fixed_mode), .active_weights(), .irq());
    rqs_engine_model u_eng (.ref_clk, .reset, .run_stop_bit, .data_read_slave_error,
        .zero_length_descriptor, .engine_idle, .iter_start);

    initial
    begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic chk_reg(input logic [32:0] got, input logic [32:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_sig(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: output %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // The request is held until pready is seen, then released for one edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] s);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'h1;
        do @(posedge ref_clk); while (pready !== 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic er);
        exp_q.push_back({er, e});
        apb(1'h0, a, 32'h0, 4'h0);
    endtask

    task automatic do_reset();
        reset <= 1'h1;
        repeat (6) @(posedge ref_clk);
        reset <= 1'h0;
        @(posedge ref_clk);
    endtask

    task automatic wait_halt();
        repeat (50) if (halted_flag !== 1'h1) @(posedge ref_clk);
    endtask

    function automatic logic [63:0] mode_of(input logic [2:0] c);
        if (c == 3'h4)
            return 64'(rqs_pkg::RQS_MODE_FAIR);
        if (c == 3'h1)
            return 64'(rqs_pkg::RQS_MODE_STRICT);
        return 64'(rqs_pkg::RQS_MODE_WRR);
    endfunction

    always @(posedge ref_clk)
    begin
        if (psel === 1'h1 && penable === 1'h1 && pready === 1'h1 && pwrite === 1'h0 && exp_q.size() > 0)
            chk_reg({pslverr, prdata}, exp_q.pop_front());
    end

    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        complete_run();
    end

    initial
    begin
        reset = 1'h1;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        pstrb = 4'h0;
        channel_enable = 16'h0;
        void'($urandom(35));
        do_reset();
        chk_sig(64'(fixed_mode), 64'(rqs_pkg::RQS_MODE_STRICT));
        rd(8'h10, 32'h0, 1'h0);
        rd(8'h14, 32'h2, 1'h0);
        rd(8'h18, 32'h11111111, 1'h0);
        rd(8'h1C, 32'h11111111, 1'h0);
        rd(8'h20, 32'h0, 1'h1);
        apb(1'h1, 8'h10, 32'hFFFFFFFF, 4'hF);
        rd(8'h10, 32'h0, 1'h0);
        $display("test reset_values done");
        // Written only while the engine is idle.
        for (int c = 0; c < 8; c++)
        begin
            wl = $urandom();
            apb(1'h1, 8'h14, {wl[31:3], 3'(c)}, 4'hF);
            rd(8'h14, {29'h0, 3'(c)}, 1'h0);
            chk_sig(64'(sched_mode), mode_of(3'(c)));
        end
        chk_sig(64'(fixed_mode), 64'(rqs_pkg::RQS_MODE_STRICT));
        $display("test scheduler done");
        channel_enable <= 16'($urandom());
        wl = $urandom();
        wh = $urandom();
        apb(1'h1, 8'h18, wl, 4'hF);
        apb(1'h1, 8'h1C, wh, 4'h5);
        wh = {8'h11, wh[23:16], 8'h11, wh[7:0]};
        rd(8'h18, wl, 1'h0);
        rd(8'h1C, wh, 1'h0);
        chk_sig(active_weights, {16{4'h1}});
        u_eng.iteration();
        chk_sig(active_weights, {wh, wl});
        $display("test weights done");
        apb(1'h1, 8'h3C, 32'h3, 4'hF);
        apb(1'h1, 8'h30, 32'h1, 4'hF);
        chk_sig(64'({run_stop_bit, halted_flag, irq}), 64'h4);
        u_eng.pulse_err(1'h1);
        wait_halt();
        chk_sig(64'({run_stop_bit, halted_flag, irq}), 64'h3);
        rd(8'h10, 32'h2, 1'h0);
        apb(1'h1, 8'h30, 32'h1, 4'hF);
        chk_sig(64'(run_stop_bit), 64'h0);
        apb(1'h1, 8'h3C, 32'h0, 4'hF);
        chk_sig(64'(irq), 64'h0);
        apb(1'h1, 8'h38, 32'h3, 4'hF);
        apb(1'h1, 8'h3C, 32'h3, 4'hF);
        chk_sig(64'(irq), 64'h0);
        $display("test slave_error done");
        do_reset();
        rd(8'h10, 32'h0, 1'h0);
        apb(1'h1, 8'h30, 32'h1, 4'hF);
        u_eng.pulse_err(1'h0);
        wait_halt();
        chk_sig(64'({run_stop_bit, halted_flag}), 64'h1);
        rd(8'h10, 32'h1, 1'h0);
        $display("test zero_length done");
        complete_run();
    end
endmodule
